// ===== logic/scp_cfg.svh
// Constants for the serial control port: register map, serial framing and timing.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SCP_NUM_REGS      26
`define SCP_ADDR_FIRST    5'h00
`define SCP_ADDR_LAST     5'h19
`define SCP_ADDR_CFG      5'h00
`define SCP_REG_RESET     8'h00
`define SCP_CFG_PINMODE   7
`define SCP_CFG_LSBFIRST  6
`define SCP_ADDR_STEP     5'h01

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define SCP_BIT_FIRST     3'h0
`define SCP_BIT_LAST      3'h7
`define SCP_BIT_STEP      3'h1
`define SCP_CNT_DONE      2'h0
`define SCP_CNT_STEP      2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCP_SYS_CLK_MHZ   200
`define SCP_SCLK_MAX_MHZ  10
`define SCP_SCLK_MIN_CYC  ((`SCP_SYS_CLK_MHZ + `SCP_SCLK_MAX_MHZ - 1) / `SCP_SCLK_MAX_MHZ)

`endif

// ===== logic/scp_pkg.sv
// Types shared by the serial control port modules.
package scp_pkg;

    typedef enum logic [0:0] {
        SCP_ST_INSTR,
        SCP_ST_DATA
    } scp_state_type;

    typedef struct packed {
        logic       isRead;
        logic [1:0] byteCount;
        logic [4:0] regAddr;
    } scp_instr_type;

endpackage

// ===== logic/scp_reg_file.sv
// Configuration register file reached through the serial control port.
`timescale 1ns/100ps
`include "scp_cfg.svh"
module scp_reg_file (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    scp_reg_if.regs   bus
);
    logic [7:0] regs_ff     [`SCP_NUM_REGS];
    logic [7:0] nxt_regs    [`SCP_NUM_REGS];

    // ----------------------------------------------------------------
    // Write path.
    // ----------------------------------------------------------------
    always_comb begin
        nxt_regs = regs_ff;
        if (bus.wrEn && bus.wrAddr <= `SCP_ADDR_LAST) begin
            nxt_regs[bus.wrAddr] = bus.wrData;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `SCP_NUM_REGS; i++) begin
                regs_ff[i] <= `SCP_REG_RESET;
            end
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // ----------------------------------------------------------------
    // Read path and port configuration bits.
    // ----------------------------------------------------------------
    assign bus.rdData   = (bus.rdAddr <= `SCP_ADDR_LAST) ? regs_ff[bus.rdAddr] : `SCP_REG_RESET;
    assign bus.pinMode  = regs_ff[`SCP_ADDR_CFG][`SCP_CFG_PINMODE];
    assign bus.lsbFirst = regs_ff[`SCP_ADDR_CFG][`SCP_CFG_LSBFIRST];
endmodule

// ===== logic/scp_reg_if.sv
// Interface between the port controller and its register file.
`timescale 1ns/100ps
interface scp_reg_if;
    logic       wrEn;
    logic [4:0] wrAddr;
    logic [7:0] wrData;
    logic [4:0] rdAddr;
    logic [7:0] rdData;
    logic       pinMode;
    logic       lsbFirst;

    modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr,
                  input rdData, input pinMode, input lsbFirst);
    modport regs (input wrEn, input wrAddr, input wrData, input rdAddr,
                  output rdData, output pinMode, output lsbFirst);
endinterface

// ===== logic/scp_serial_port.sv
// Serial control port: instruction decode, data phase and pin drive.
//
// Notes on behaviour
// - Each cycle opens with an eight-edge instruction byte, then the data phase.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6 and 5 give one to four data bytes.
// - Bits 4 to 0 give the first register; later addresses are generated.
// - After a cycle ends, the next eight rising edges form a new instruction.
// - Instruction and write data are sampled on rising serial clock edges.
// - Read data changes on falling serial clock edges.
// - Chip select is active low; while high both data outputs float.
// - Chip select high freezes the cycle; it resumes when select returns low.
// - Register 0 bit 7 zero shares the data pin; one uses the output pin.
// - In shared-pin mode the separate output pin is never driven.
// - Resync high aborts the cycle, keeps registers, next cycle starts fresh.
// - Register 0 bit 6 selects bit order; reset gives most significant first.
// - Most-significant-first multibyte transfers decrement the register address.
// - Least-significant-first multibyte transfers increment the register address.
// - Every register can be read and written, single or multibyte.
// - Writing register 0 changes pin mode and bit order immediately.
// - Generated address wraps 19h to 0h up, 0h to 19h down.
`timescale 1ns/100ps
`include "scp_cfg.svh"
module scp_serial_port (
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    input  wire logic  serialClock,
    input  wire logic  chipSelectN,
    input  wire logic  resyncIn,
    input  wire logic  dataIoIn,
    output logic       dataIoOut,
    output logic       dataIoOe,
    output logic       serialDataOut,
    output logic       serialDataOutOe,
    output logic       regWrStrobe,
    output logic [4:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic       pinModeOut,
    output logic       lsbFirstOut
);
    import scp_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers.
    // ----------------------------------------------------------------
    logic sclkS;
    logic csNS;
    logic resyncS;
    logic dinS;

    scp_sync #(.RESET_VAL(1'b0)) u_syncSclk (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (serialClock),
        .syncOut (sclkS)
    );
    scp_sync #(.RESET_VAL(1'b1)) u_syncCs (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (chipSelectN),
        .syncOut (csNS)
    );
    scp_sync #(.RESET_VAL(1'b0)) u_syncResync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (resyncIn),
        .syncOut (resyncS)
    );
    scp_sync #(.RESET_VAL(1'b0)) u_syncData (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (dataIoIn),
        .syncOut (dinS)
    );

    // ----------------------------------------------------------------
    // Register file.
    // ----------------------------------------------------------------
    scp_reg_if regBus ();

    scp_reg_file u_regs (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .bus     (regBus)
    );

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    scp_state_type state_ff;
    scp_state_type nxt_state;
    logic          sclkPrev_ff;
    logic          nxt_sclkPrev;
    logic [2:0]    bitCnt_ff;
    logic [2:0]    nxt_bitCnt;
    logic [7:0]    shift_ff;
    logic [7:0]    nxt_shift;
    logic          isRead_ff;
    logic          nxt_isRead;
    logic [1:0]    bytesLeft_ff;
    logic [1:0]    nxt_bytesLeft;
    logic [4:0]    addr_ff;
    logic [4:0]    nxt_addr;
    logic          txBit_ff;
    logic          nxt_txBit;
    logic          dataIoOe_ff;
    logic          nxt_dataIoOe;
    logic          outOe_ff;
    logic          nxt_outOe;
    logic          wrStrobe_ff;
    logic          nxt_wrStrobe;
    logic [4:0]    wrAddr_ff;
    logic [4:0]    nxt_wrAddr;
    logic [7:0]    wrData_ff;
    logic [7:0]    nxt_wrData;
    logic          pinMode_ff;
    logic          lsbFirst_ff;

    logic          sclkRise;
    logic          sclkFall;
    logic [7:0]    rxByte;
    logic [4:0]    stepAddr;
    logic [2:0]    txIdx;
    scp_instr_type instr;
    logic          driving;

    // ----------------------------------------------------------------
    // Serial edges and bit order.
    // ----------------------------------------------------------------
    // Edges count only while selected, so a deselect freezes the cycle.
    assign sclkRise = ~csNS & sclkS & ~sclkPrev_ff;
    assign sclkFall = ~csNS & ~sclkS & sclkPrev_ff;

    // Bit order is read live, so a write to register 0 acts at once.
    assign rxByte = regBus.lsbFirst ? {dinS, shift_ff[7:1]}
                                    : {shift_ff[6:0], dinS};
    assign instr  = scp_instr_type'(rxByte);
    assign txIdx  = regBus.lsbFirst ? bitCnt_ff : (`SCP_BIT_LAST - bitCnt_ff);

    // Address generator with wrap at the ends of the map.
    always_comb begin
        if (regBus.lsbFirst) begin
            stepAddr = (addr_ff == `SCP_ADDR_LAST) ? `SCP_ADDR_FIRST
                                                   : addr_ff + `SCP_ADDR_STEP;
        end else begin
            stepAddr = (addr_ff == `SCP_ADDR_FIRST) ? `SCP_ADDR_LAST
                                                    : addr_ff - `SCP_ADDR_STEP;
        end
    end

    assign regBus.rdAddr = addr_ff;
    assign regBus.wrEn   = wrStrobe_ff;
    assign regBus.wrAddr = wrAddr_ff;
    assign regBus.wrData = wrData_ff;

    // ----------------------------------------------------------------
    // Next-state logic.
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state     = state_ff;
        nxt_sclkPrev  = sclkS;
        nxt_bitCnt    = bitCnt_ff;
        nxt_shift     = shift_ff;
        nxt_isRead    = isRead_ff;
        nxt_bytesLeft = bytesLeft_ff;
        nxt_addr      = addr_ff;
        nxt_txBit     = txBit_ff;
        nxt_wrStrobe  = 1'b0;
        nxt_wrAddr    = wrAddr_ff;
        nxt_wrData    = wrData_ff;
        if (resyncS) begin
            nxt_state  = SCP_ST_INSTR;
            nxt_bitCnt = `SCP_BIT_FIRST;
        end else if (sclkRise) begin
            nxt_shift  = rxByte;
            nxt_bitCnt = bitCnt_ff + `SCP_BIT_STEP;
            if (bitCnt_ff == `SCP_BIT_LAST) begin
                case (state_ff)
                    SCP_ST_INSTR: begin
                        nxt_isRead    = instr.isRead;
                        nxt_bytesLeft = instr.byteCount;
                        nxt_addr      = instr.regAddr;
                        nxt_state     = SCP_ST_DATA;
                    end
                    SCP_ST_DATA: begin
                        if (!isRead_ff) begin
                            nxt_wrStrobe = 1'b1;
                            nxt_wrAddr   = addr_ff;
                            nxt_wrData   = rxByte;
                        end
                        if (bytesLeft_ff == `SCP_CNT_DONE) begin
                            nxt_state = SCP_ST_INSTR;
                        end else begin
                            nxt_bytesLeft = bytesLeft_ff - `SCP_CNT_STEP;
                            nxt_addr      = stepAddr;
                        end
                    end
                    default: begin
                        nxt_state = SCP_ST_INSTR;
                    end
                endcase
            end
        end else if (sclkFall && state_ff == SCP_ST_DATA && isRead_ff) begin
            nxt_txBit = regBus.rdData[txIdx];
        end
    end

    // ----------------------------------------------------------------
    // Pin drive next values.
    // ----------------------------------------------------------------
    // Drivers float while deselected or outside a read data phase.
    assign driving = ~csNS & ~resyncS & (nxt_state == SCP_ST_DATA) & nxt_isRead;

    always_comb begin
        nxt_dataIoOe = driving & ~regBus.pinMode;
        nxt_outOe    = driving & regBus.pinMode;
    end

    // ----------------------------------------------------------------
    // Link state registers.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff     <= SCP_ST_INSTR;
            sclkPrev_ff  <= 1'b0;
            bitCnt_ff    <= `SCP_BIT_FIRST;
            shift_ff     <= `SCP_REG_RESET;
            isRead_ff    <= 1'b0;
            bytesLeft_ff <= `SCP_CNT_DONE;
            addr_ff      <= `SCP_ADDR_FIRST;
        end else begin
            state_ff     <= nxt_state;
            sclkPrev_ff  <= nxt_sclkPrev;
            bitCnt_ff    <= nxt_bitCnt;
            shift_ff     <= nxt_shift;
            isRead_ff    <= nxt_isRead;
            bytesLeft_ff <= nxt_bytesLeft;
            addr_ff      <= nxt_addr;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive registers.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txBit_ff    <= 1'b0;
            dataIoOe_ff <= 1'b0;
            outOe_ff    <= 1'b0;
        end else begin
            txBit_ff    <= nxt_txBit;
            dataIoOe_ff <= nxt_dataIoOe;
            outOe_ff    <= nxt_outOe;
        end
    end

    // ----------------------------------------------------------------
    // Write echo registers.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrStrobe_ff <= 1'b0;
            wrAddr_ff   <= `SCP_ADDR_FIRST;
            wrData_ff   <= `SCP_REG_RESET;
        end else begin
            wrStrobe_ff <= nxt_wrStrobe;
            wrAddr_ff   <= nxt_wrAddr;
            wrData_ff   <= nxt_wrData;
        end
    end

    // ----------------------------------------------------------------
    // Configuration copy registers.
    // ----------------------------------------------------------------
    logic          nxt_pinMode;
    logic          nxt_lsbFirst;

    always_comb begin
        nxt_pinMode  = regBus.pinMode;
        nxt_lsbFirst = regBus.lsbFirst;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMode_ff  <= 1'b0;
            lsbFirst_ff <= 1'b0;
        end else begin
            pinMode_ff  <= nxt_pinMode;
            lsbFirst_ff <= nxt_lsbFirst;
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    assign dataIoOut       = txBit_ff;
    assign dataIoOe        = dataIoOe_ff;
    assign serialDataOut   = txBit_ff;
    assign serialDataOutOe = outOe_ff;
    assign regWrStrobe     = wrStrobe_ff;
    assign regWrAddr       = wrAddr_ff;
    assign regWrData       = wrData_ff;
    assign pinModeOut      = pinMode_ff;
    assign lsbFirstOut     = lsbFirst_ff;
endmodule

// ===== logic/scp_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
module scp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_ff <= RESET_VAL;
            stage2_ff <= RESET_VAL;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule

// ===== tb/scp_host_model.sv
// Host model that drives frames into the serial control port.
`timescale 1ns/100ps
module scp_host_model (
    output logic      serialClock,
    output logic      chipSelectN,
    output wire       dataIoIn,
    input  wire logic dataIoOut,
    input  wire logic dataIoOe,
    input  wire logic serialDataOut,
    input  wire logic serialDataOutOe
);
    logic lsb = 1'b0;
    logic sepPin = 1'b0;
    logic pauseOnce = 1'b0;
    logic drv = 1'b0;
    logic txBit = 1'b0;
    logic junk = 1'b0;
    wire  sdoLine;
    always #7 junk = ~junk;
    assign dataIoIn = dataIoOe ? dataIoOut : (drv ? txBit : junk);
    assign sdoLine = serialDataOutOe ? serialDataOut : junk;
    initial begin
        serialClock = 1'b0;
        chipSelectN = 1'b1;
    end
    task automatic shift_byte(input logic [7:0] tx, input logic send, output logic [7:0] rx);
        for (int i = 0; i < 8; i++) begin
            serialClock <= 1'b0;
            drv <= send;
            txBit <= tx[lsb ? i : 7 - i];
            #32;
            if (pauseOnce && !send && i == 3) begin
                chipSelectN <= 1'b1;
                #300;
                chipSelectN <= 1'b0;
                pauseOnce <= 1'b0;
                #40;
            end
            rx[lsb ? i : 7 - i] = sepPin ? sdoLine : dataIoIn;
            serialClock <= 1'b1;
            #32;
        end
    endtask
    task automatic open_frame();
        chipSelectN <= 1'b0;
        #40;
    endtask
    task automatic close_frame();
        #40;
        drv <= 1'b0;
        chipSelectN <= 1'b1;
        #100;
    endtask
    task automatic frame(input logic [7:0] ins, input logic [31:0] wd, output logic [31:0] rd);
        logic [7:0] b;
        open_frame();
        shift_byte(ins, 1'b1, b);
        for (int k = 0; k <= ins[6:5]; k++) begin
            shift_byte(wd[8*k +: 8], !ins[7], b);
            rd[8*k +: 8] = b;
        end
        close_frame();
    endtask
endmodule

// ===== tb/scp_port_assertions.sv
// Concurrent checks on the serial control port pins.
`timescale 1ns/100ps
module scp_port_assertions (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       serialClock,
    input wire logic       chipSelectN,
    input wire logic       resyncIn,
    input wire logic       dataIoIn,
    input wire logic       dataIoOut,
    input wire logic       dataIoOe,
    input wire logic       serialDataOut,
    input wire logic       serialDataOutOe,
    input wire logic       regWrStrobe,
    input wire logic [4:0] regWrAddr,
    input wire logic [7:0] regWrData,
    input wire logic       pinModeOut,
    input wire logic       lsbFirstOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence s_deselected;
        chipSelectN [*8];
    endsequence
    sequence s_resync_held;
        resyncIn [*6];
    endsequence
    sequence s_recent_strobe;
        $past(regWrStrobe) || $past(regWrStrobe, 2) || $past(regWrStrobe, 3);
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_cs_float;
        s_deselected |-> !dataIoOe && !serialDataOutOe;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("data pin driven while deselected");
    property p_cs_frozen;
        s_deselected |-> !regWrStrobe;
    endproperty
    a_cs_frozen: assert property (p_cs_frozen) else $error("write while deselected");
    property p_resync;
        s_resync_held |-> !dataIoOe && !serialDataOutOe && !regWrStrobe;
    endproperty
    a_resync: assert property (p_resync) else $error("activity during resync");
    property p_cfg_source;
        $changed({pinModeOut, lsbFirstOut}) |-> s_recent_strobe ##0
            (regWrAddr == 5'h00 && {pinModeOut, lsbFirstOut} == regWrData[7:6]);
    endproperty
    a_cfg_source: assert property (p_cfg_source) else $error("config bits changed alone");
    property p_strobe_gap;
        regWrStrobe |=> !regWrStrobe [*8];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("write strobes too close");
    property p_wr_hold;
        !regWrStrobe |-> $stable(regWrAddr) && $stable(regWrData);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write echo moved");
    property p_oe_excl;
        !(dataIoOe && serialDataOutOe);
    endproperty
    a_oe_excl: assert property (p_oe_excl) else $error("both data pins driven");
    property p_sep_idle;
        !pinModeOut [*3] |-> !serialDataOutOe;
    endproperty
    a_sep_idle: assert property (p_sep_idle) else $error("output pin driven in shared mode");
    property p_shared_idle;
        pinModeOut [*3] |-> !dataIoOe;
    endproperty
    a_shared_idle: assert property (p_shared_idle) else $error("shared pin driven");
endmodule
bind scp_serial_port scp_port_assertions chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .serialClock(serialClock), .chipSelectN(chipSelectN), .resyncIn(resyncIn),
    .dataIoIn(dataIoIn), .dataIoOut(dataIoOut), .dataIoOe(dataIoOe),
    .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe),
    .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .pinModeOut(pinModeOut), .lsbFirstOut(lsbFirstOut));

// ===== tb/serial_control_port_test.sv
// Self-checking bench for the serial control port.
`timescale 1ns/100ps
module serial_control_port_test;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       resyncIn = 1'b0;
    wire        serialClock, chipSelectN, dataIoIn, dataIoOut, dataIoOe;
    wire        serialDataOut, serialDataOutOe, regWrStrobe, pinModeOut, lsbFirstOut;
    wire  [4:0] regWrAddr;
    wire  [7:0] regWrData;
    int         bad_count = 0;
    int         compares = 0;
    int         n;
    logic [7:0] lfsrState = 8'h51;
    logic [7:0] shadow [0:31];
    logic [4:0] wrSeen [$];
    logic [7:0] wdSeen [$];
    logic [4:0] a;
    logic [31:0] d;
    logic [7:0] b;
    initial forever #2.5 sys_clk = ~sys_clk;
    scp_serial_port DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .serialClock(serialClock),
        .chipSelectN(chipSelectN), .resyncIn(resyncIn), .dataIoIn(dataIoIn),
        .dataIoOut(dataIoOut), .dataIoOe(dataIoOe), .serialDataOut(serialDataOut),
        .serialDataOutOe(serialDataOutOe), .regWrStrobe(regWrStrobe),
        .regWrAddr(regWrAddr), .regWrData(regWrData), .pinModeOut(pinModeOut),
        .lsbFirstOut(lsbFirstOut));
    scp_host_model host (.serialClock(serialClock), .chipSelectN(chipSelectN),
        .dataIoIn(dataIoIn), .dataIoOut(dataIoOut), .dataIoOe(dataIoOe),
        .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe));
    always @(posedge sys_clk) begin
        if (regWrStrobe === 1'b1) begin
            wrSeen.push_back(regWrAddr);
            wdSeen.push_back(regWrData);
        end
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr();
        lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
        return lfsrState;
    endfunction
    function automatic logic [4:0] next_addr(input logic [4:0] p);
        if (host.lsb) return (p == 5'h19) ? 5'h00 : p + 5'h01;
        return (p == 5'h00) ? 5'h19 : p - 5'h01;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic xfer(input logic rd, input logic [4:0] s, input int cnt, input logic [31:0] w);
        logic [31:0] got;
        logic [4:0]  p;
        p = s;
        wrSeen.delete();
        wdSeen.delete();
        host.frame({rd, 2'(cnt - 1), s}, w, got);
        repeat (10) @(posedge sys_clk);
        for (int k = 0; k < cnt; k++) begin
            if (rd) check(got[8*k +: 8], shadow[p]);
            else check({3'h0, wrSeen[k]}, {3'h0, p});
            if (!rd) check(wdSeen[k], w[8*k +: 8]);
            if (!rd && p <= 5'h19) shadow[p] = w[8*k +: 8];
            p = next_addr(p);
        end
        if (!rd && s == 5'h00 && cnt == 1) begin
            check({6'h0, pinModeOut, lsbFirstOut}, {6'h0, w[7:6]});
            host.lsb = w[6];
            host.sepPin = w[7];
        end
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        for (int i = 0; i < 32; i++) shadow[i] = 8'h00;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check({6'h0, pinModeOut, lsbFirstOut}, 8'h00);
        xfer(1'b0, 5'h05, 1, 32'h0000005A);
        xfer(1'b1, 5'h05, 1, 32'h0);
        xfer(1'b0, 5'h01, 4, 32'hC3B20090);
        xfer(1'b1, 5'h01, 4, 32'h0);
        xfer(1'b0, 5'h1A, 1, 32'h00000077);
        xfer(1'b1, 5'h1A, 1, 32'h0);
        $display("fixed transfer test done");
        for (int j = 0; j < 12; j++) begin
            a = 5'(lfsr() % 8'h16 + 8'h04);
            n = int'(lfsr() % 8'h04) + 1;
            d = {lfsr(), lfsr(), lfsr(), lfsr()};
            xfer(1'b0, a, n, d);
            xfer(1'b1, a, n, 32'h0);
        end
        $display("random transfer test done");
        host.open_frame();
        host.shift_byte(8'h07, 1'b1, b);
        host.shift_byte(8'hE1, 1'b1, b);
        host.shift_byte(8'h87, 1'b1, b);
        host.shift_byte(8'h00, 1'b0, b);
        host.close_frame();
        check(b, 8'hE1);
        shadow[7] = 8'hE1;
        host.open_frame();
        host.shift_byte(8'h07, 1'b1, b);
        @(posedge sys_clk) resyncIn <= 1'b1;
        repeat (10) @(posedge sys_clk);
        resyncIn <= 1'b0;
        repeat (5) @(posedge sys_clk);
        host.shift_byte(8'h87, 1'b1, b);
        host.shift_byte(8'h00, 1'b0, b);
        host.close_frame();
        check(b, 8'hE1);
        $display("chained and resync test done");
        xfer(1'b0, 5'h00, 1, 32'h00000040);
        xfer(1'b0, 5'h18, 4, 32'h3C406655);
        xfer(1'b1, 5'h18, 4, 32'h0);
        xfer(1'b0, 5'h00, 1, 32'h000000C0);
        xfer(1'b1, 5'h05, 1, 32'h0);
        host.pauseOnce = 1'b1;
        xfer(1'b1, 5'h18, 2, 32'h0);
        xfer(1'b0, 5'h00, 1, 32'h00000000);
        xfer(1'b1, 5'h01, 1, 32'h0);
        $display("mode and freeze test done");
        stop_test();
    end
endmodule
